//--- du_pkg.sv
// Constants, register map and state encodings for the dual serial block.
// Assumes an 8-bit register port with byte offsets and one bus clock.
package du_pkg;

  // Register offsets of the first unit.
  localparam logic [7:0] DU0_DIVL_OFS  = 8'hbd;
  localparam logic [7:0] DU0_CON1_OFS  = 8'hbe;
  localparam logic [7:0] DU0_CON2_OFS  = 8'hbf;
  localparam logic [7:0] DU0_STAT_OFS  = 8'hc0;
  localparam logic [7:0] DU0_DATA_OFS  = 8'hc1;
  // Shared pin control offsets.
  localparam logic [7:0] DU_SWAP_OFS   = 8'hc2;
  localparam logic [7:0] DU_OFF_OFS    = 8'hc3;
  // Register offsets of the second unit.
  localparam logic [7:0] DU1_DIVL_OFS  = 8'hc5;
  localparam logic [7:0] DU1_CON1_OFS  = 8'hc6;
  localparam logic [7:0] DU1_CON2_OFS  = 8'hc7;
  localparam logic [7:0] DU1_STAT_OFS  = 8'hc8;
  localparam logic [7:0] DU1_DATA_OFS  = 8'hc9;

  // Control register one fields.
  localparam int C1_EN    = 6;
  localparam int C1_RXEN  = 5;
  localparam int C1_MULTI = 4;
  localparam int C1_STOP2 = 3;
  localparam int C1_NINE  = 2;
  localparam int C1_PAREN = 1;
  localparam int C1_ODD   = 0;
  // Control register two fields.
  localparam int C2_TXIE  = 3;
  localparam int C2_RXIE  = 2;
  localparam int C2_DIVH  = 1;
  // Status register fields.
  localparam int ST_R8    = 6;
  localparam int ST_T8    = 5;
  localparam int ST_TI    = 4;
  localparam int ST_RI    = 3;
  localparam int ST_OVR   = 2;
  localparam int ST_FRM   = 1;
  localparam int ST_PAR   = 0;

  // Reset values.
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [6:0] CON1_RST = 7'h00;
  localparam logic [3:0] CON2_RST = 4'hc;
  localparam logic [7:0] DIVL_RST = 8'h00;
  localparam logic [1:0] PIN_RST  = 2'h0;

  // Oversampling: sixteen ticks per bit, start checked at mid bit.
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_MID  = 4'h7;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [9:0] DIV_ZERO = 10'h000;
  localparam logic [9:0] DIV_ONE  = 10'h001;

  // Pad index inside a unit's pad pair.
  localparam int PAD_A = 0;
  localparam int PAD_B = 1;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_EXTRA = 3'b011,
    TX_STOP  = 3'b100,
    TX_STOP2 = 3'b101
  } du_tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_EXTRA = 3'b011,
    RX_STOP  = 3'b100,
    RX_STOP2 = 3'b101
  } du_rx_state_type;

endpackage

//--- du_top.sv
// Two identical serial transceivers with a shared pin swap and pin disable.
// Assumes a one-cycle register port and pad inputs synchronous to clk.
// What this block does
// [RULE_01] Ten-bit divisor; zero stops the baud clock.
// [RULE_02] Bit rate is clock over sixteen times divisor.
// [RULE_03] Unit runs only while its enable is set.
// [RULE_04] Receiver runs only while receive enable set.
// [RULE_05] Bit four selects multiprocessor mode.
// [RULE_06] Bit three selects one or two stops.
// [RULE_07] Bit two selects nine or eight data bits.
// [RULE_08] Parity generated and checked; odd or even.
// [RULE_09] Interrupt enables gate requests, reset to one.
// [RULE_10] Ninth received bit readable, read only.
// [RULE_11] Ninth transmit bit writable unless parity on.
// [RULE_12] Transmit flag shows empty buffer; write zero clears.
// [RULE_13] Receive flag shows full buffer; write zero clears.
// [RULE_14] Arrival on full buffer discarded, overflow flagged.
// [RULE_15] Bad stop bit sets the framing flag.
// [RULE_16] Parity mismatch sets the parity flag.
// [RULE_17] Data address reads receive, writes transmit buffer.
// [RULE_18] Swap bits exchange a unit's two pins.
// [RULE_19] Disable bits disconnect the transmit and receive paths, whatever the swap.
// [RULE_20] Low start, LSB first, extra bit, stops.
// [RULE_21] Multiprocessor mode with nine data bits accepts only ninth-bit-set characters.
`timescale 1ns/1ps

module du_top
  import du_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [3:0] pad_in,
  output logic      [3:0] pad_out,
  output logic      [3:0] pad_oe,
  output logic      [1:0] serial_irq
);

  // Address match, shared by every register decode.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // Parity of a character; odd type inverts so the total count is odd.
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  logic [1:0] swap_reg;
  logic [3:0] off_reg;
  logic [7:0] rd_next;
  logic [7:0] rdata_reg;
  logic [7:0] divl_rd [2];
  logic [7:0] con1_rd [2];
  logic [7:0] con2_rd [2];
  logic [7:0] stat_rd [2];
  logic [7:0] data_rd [2];

  wire wr_swap = reg_wr && hit(reg_addr, DU_SWAP_OFS);
  wire wr_off  = reg_wr && hit(reg_addr, DU_OFF_OFS);

  // Shared pin control; reserved bits are not stored and read as zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swap_reg <= PIN_RST;
      off_reg  <= {PIN_RST, PIN_RST};
    end else begin
      if (wr_swap) swap_reg <= reg_wdata[1:0];
      if (wr_off)  off_reg  <= reg_wdata[3:0];
    end
  end

  genvar u;
  generate
    for (u = 0; u < 2; u++) begin : g_unit
      localparam logic [7:0] O_DIVL = (u == 0) ? DU0_DIVL_OFS : DU1_DIVL_OFS;
      localparam logic [7:0] O_CON1 = (u == 0) ? DU0_CON1_OFS : DU1_CON1_OFS;
      localparam logic [7:0] O_CON2 = (u == 0) ? DU0_CON2_OFS : DU1_CON2_OFS;
      localparam logic [7:0] O_STAT = (u == 0) ? DU0_STAT_OFS : DU1_STAT_OFS;
      localparam logic [7:0] O_DATA = (u == 0) ? DU0_DATA_OFS : DU1_DATA_OFS;

      logic [7:0]      divl_reg;
      logic [6:0]      con1_reg;
      logic [3:0]      con2_reg;
      logic            t8_reg;
      logic            r8_reg;
      logic            ti_reg;
      logic            ri_reg;
      logic            ovr_reg;
      logic            frm_reg;
      logic            perr_reg;
      logic [7:0]      rxbuf_reg;
      logic [7:0]      txbuf_reg;
      logic            pend_reg;
      logic [9:0]      cnt_reg;
      du_tx_state_type tx_st_reg;
      logic [3:0]      tx_sub_reg;
      logic [3:0]      tx_bit_reg;
      logic [7:0]      tx_sh_reg;
      logic            tx_ext_reg;
      logic            tx_line_reg;
      du_rx_state_type rx_st_reg;
      logic [3:0]      rx_sub_reg;
      logic [3:0]      rx_bit_reg;
      logic [7:0]      rx_sh_reg;
      logic            rx_ext_reg;
      logic            rx_ferr_reg;
      logic [1:0]      po_reg;
      logic [1:0]      pe_reg;
      logic            ti_next;
      logic            ri_next;
      logic            ovr_next;
      logic            frm_next;
      logic            perr_next;

      // Register strobes of this unit.
      wire wr_divl = reg_wr && hit(reg_addr, O_DIVL);
      wire wr_con1 = reg_wr && hit(reg_addr, O_CON1);
      wire wr_con2 = reg_wr && hit(reg_addr, O_CON2);
      wire wr_stat = reg_wr && hit(reg_addr, O_STAT);
      wire wr_data = reg_wr && hit(reg_addr, O_DATA);

      // Mode decode from control register one.
      wire unit_on   = con1_reg[C1_EN];                        // see [RULE_03]
      wire rx_on     = unit_on && con1_reg[C1_RXEN];           // see [RULE_04]
      wire stop2     = con1_reg[C1_STOP2];                     // see [RULE_06]
      wire nine      = con1_reg[C1_NINE];                      // see [RULE_07]
      wire par_en    = con1_reg[C1_PAREN];                     // see [RULE_08]
      wire has_extra = nine || par_en;
      wire multi     = con1_reg[C1_MULTI];                     // see [RULE_05]

      // Baud tick at sixteen times the bit rate; a zero divisor never ticks.
      wire [9:0] divisor = {con2_reg[C2_DIVH:0], divl_reg};    // see [RULE_01]
      wire [9:0] div_m1  = divisor - DIV_ONE;
      wire       div_ok  = divisor != DIV_ZERO;
      wire       tick    = unit_on && div_ok && (cnt_reg >= div_m1); // see [RULE_02]

      always_ff @(posedge clk or posedge rst) begin
        if (rst)               cnt_reg <= DIV_ZERO;
        else if (!tick && unit_on && div_ok) cnt_reg <= cnt_reg + DIV_ONE;
        else                   cnt_reg <= DIV_ZERO;
      end

      // Control and divisor registers.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          divl_reg <= DIVL_RST;
          con1_reg <= CON1_RST;
          con2_reg <= CON2_RST;                                // see [RULE_09]
        end else begin
          if (wr_divl) divl_reg <= reg_wdata;
          if (wr_con1) con1_reg <= reg_wdata[6:0];
          if (wr_con2) con2_reg <= reg_wdata[3:0];
        end
      end

      // Transmit side: a shifter is loaded from the buffer on an idle tick.
      wire tx_load = (tx_st_reg == TX_IDLE) && pend_reg && tick;
      wire tx_end  = tick && (tx_sub_reg == SUB_LAST);

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          txbuf_reg <= DATA_RST;
          pend_reg  <= 1'b0;
        end else begin
          if (wr_data) txbuf_reg <= reg_wdata;                 // see [RULE_17]
          pend_reg <= wr_data || (pend_reg && !tx_load);
        end
      end

      // Frame sequencer; disabling the unit aborts a frame and idles the line.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          tx_st_reg   <= TX_IDLE;
          tx_sub_reg  <= SUB_LAST;
          tx_bit_reg  <= 4'h0;
          tx_sh_reg   <= DATA_RST;
          tx_ext_reg  <= 1'b0;
          tx_line_reg <= 1'b1;
        end else if (!unit_on) begin
          tx_st_reg   <= TX_IDLE;
          tx_line_reg <= 1'b1;
        end else if (tx_load) begin
          tx_sh_reg   <= txbuf_reg;
          tx_ext_reg  <= par_en ? par_of(txbuf_reg, con1_reg[C1_ODD]) : t8_reg; // see [RULE_08]
          tx_st_reg   <= TX_START;
          tx_sub_reg  <= 4'h0;
          tx_line_reg <= 1'b0;                                 // see [RULE_20]
        end else if (tick && tx_st_reg != TX_IDLE) begin
          tx_sub_reg <= tx_sub_reg + 4'h1;
          if (tx_end) begin
            case (tx_st_reg)
              TX_START: begin
                tx_st_reg   <= TX_DATA;
                tx_bit_reg  <= 4'h0;
                tx_line_reg <= tx_sh_reg[0];
              end
              TX_DATA: begin
                tx_sh_reg  <= {1'b1, tx_sh_reg[7:1]};
                tx_bit_reg <= tx_bit_reg + 4'h1;
                if (tx_bit_reg != BIT_LAST) begin
                  tx_line_reg <= tx_sh_reg[1];
                end else if (has_extra) begin                  // see [RULE_07]
                  tx_st_reg   <= TX_EXTRA;
                  tx_line_reg <= tx_ext_reg;
                end else begin
                  tx_st_reg   <= TX_STOP;
                  tx_line_reg <= 1'b1;
                end
              end
              TX_EXTRA: begin
                tx_st_reg   <= TX_STOP;
                tx_line_reg <= 1'b1;
              end
              TX_STOP:  tx_st_reg <= stop2 ? TX_STOP2 : TX_IDLE; // see [RULE_06]
              default:  tx_st_reg <= TX_IDLE;
            endcase
          end
        end
      end

      // Receive side: pad choice follows swap, a disabled receiver reads idle.
      wire rx_pad  = swap_reg[u] ? pad_in[2*u+PAD_A] : pad_in[2*u+PAD_B]; // see [RULE_18]
      wire rx_line = off_reg[2*u+1] ? 1'b1 : rx_pad;            // see [RULE_19]
      wire rx_end  = tick && (rx_sub_reg == SUB_LAST);
      wire rx_done = rx_end && ((rx_st_reg == RX_STOP && !stop2) || rx_st_reg == RX_STOP2);
      wire bad_frm = !rx_line || (rx_st_reg == RX_STOP2 && rx_ferr_reg); // see [RULE_15]
      wire bad_par = par_en && (par_of(rx_sh_reg, con1_reg[C1_ODD]) != rx_ext_reg); // see [RULE_16]
      wire addr_ok = !(multi && nine && !rx_ext_reg);          // see [RULE_21]
      wire store   = rx_done && addr_ok && !ri_reg;
      wire lost    = rx_done && addr_ok && ri_reg;             // see [RULE_14]

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          rx_st_reg   <= RX_IDLE;
          rx_sub_reg  <= 4'h0;
          rx_bit_reg  <= 4'h0;
          rx_sh_reg   <= DATA_RST;
          rx_ext_reg  <= 1'b0;
          rx_ferr_reg <= 1'b0;
        end else if (!rx_on) begin
          rx_st_reg <= RX_IDLE;
        end else if (tick) begin
          rx_sub_reg <= rx_sub_reg + 4'h1;
          case (rx_st_reg)
            RX_IDLE: begin
              rx_sub_reg <= 4'h0;
              if (!rx_line) rx_st_reg <= RX_START;
            end
            RX_START: begin
              // A start that is high again at mid bit was a glitch.
              if (rx_sub_reg == SUB_MID) begin
                rx_sub_reg <= 4'h0;
                rx_bit_reg <= 4'h0;
                rx_st_reg  <= rx_line ? RX_IDLE : RX_DATA;
              end
            end
            RX_DATA: begin
              if (rx_end) begin
                rx_sh_reg  <= {rx_line, rx_sh_reg[7:1]};       // see [RULE_20]
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_bit_reg == BIT_LAST) rx_st_reg <= has_extra ? RX_EXTRA : RX_STOP;
              end
            end
            RX_EXTRA: begin
              if (rx_end) begin
                rx_ext_reg <= rx_line;
                rx_st_reg  <= RX_STOP;
              end
            end
            RX_STOP: begin
              if (rx_end) begin
                rx_ferr_reg <= !rx_line;
                rx_st_reg   <= stop2 ? RX_STOP2 : RX_IDLE;     // see [RULE_06]
              end
            end
            default: if (rx_end) rx_st_reg <= RX_IDLE;
          endcase
        end
      end

      // Flag updates; a hardware set wins over a software clear in one cycle.
      wire clr_ti  = wr_stat && !reg_wdata[ST_TI];
      wire clr_ri  = wr_stat && !reg_wdata[ST_RI];
      wire clr_ovr = wr_stat && !reg_wdata[ST_OVR];
      wire clr_frm = wr_stat && !reg_wdata[ST_FRM];
      wire clr_par = wr_stat && !reg_wdata[ST_PAR];

      always_comb begin
        ti_next   = tx_load || (ti_reg && !clr_ti && !wr_data); // see [RULE_12]
        ri_next   = store || (ri_reg && !clr_ri);              // see [RULE_13]
        ovr_next  = lost || (ovr_reg && !clr_ovr);             // see [RULE_14]
        frm_next  = (rx_done && bad_frm) || (frm_reg && !clr_frm); // see [RULE_15]
        perr_next = (rx_done && bad_par) || (perr_reg && !clr_par); // see [RULE_16]
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ti_reg    <= 1'b0;
          ri_reg    <= 1'b0;
          ovr_reg   <= 1'b0;
          frm_reg   <= 1'b0;
          perr_reg  <= 1'b0;
          t8_reg    <= 1'b0;
          r8_reg    <= 1'b0;
          rxbuf_reg <= DATA_RST;
        end else begin
          ti_reg   <= ti_next;
          ri_reg   <= ri_next;
          ovr_reg  <= ovr_next;
          frm_reg  <= frm_next;
          perr_reg <= perr_next;
          if (wr_stat && !par_en) t8_reg <= reg_wdata[ST_T8];  // see [RULE_11]
          if (store) begin
            rxbuf_reg <= rx_sh_reg;                            // see [RULE_17]
            r8_reg    <= rx_ext_reg;                           // see [RULE_10]
          end
        end
      end

      // Pads are registered so they never glitch on a swap change.
      wire tx_drive = unit_on && !off_reg[2*u];                // see [RULE_19]
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          po_reg <= 2'b11;
          pe_reg <= 2'b00;
        end else begin
          po_reg <= {tx_line_reg, tx_line_reg};
          pe_reg[PAD_A] <= tx_drive && !swap_reg[u];           // see [RULE_18]
          pe_reg[PAD_B] <= tx_drive && swap_reg[u];
        end
      end

      assign pad_out[2*u+1:2*u] = po_reg;
      assign pad_oe[2*u+1:2*u]  = pe_reg;
      assign serial_irq[u] = (ti_reg && con2_reg[C2_TXIE]) || (ri_reg && con2_reg[C2_RXIE]); // see [RULE_09]

      // Read views; reserved bits read as zero.
      assign divl_rd[u] = divl_reg;
      assign con1_rd[u] = {1'b0, con1_reg};
      assign con2_rd[u] = {4'h0, con2_reg};
      assign stat_rd[u] = {1'b0, r8_reg, t8_reg, ti_reg, ri_reg, ovr_reg, frm_reg, perr_reg};
      assign data_rd[u] = rxbuf_reg;
    end
  endgenerate

  // Read decode; unmapped addresses read as zero.
  always_comb begin
    if (hit(reg_addr, DU0_DIVL_OFS))      rd_next = divl_rd[0];
    else if (hit(reg_addr, DU0_CON1_OFS)) rd_next = con1_rd[0];
    else if (hit(reg_addr, DU0_CON2_OFS)) rd_next = con2_rd[0];
    else if (hit(reg_addr, DU0_STAT_OFS)) rd_next = stat_rd[0];
    else if (hit(reg_addr, DU0_DATA_OFS)) rd_next = data_rd[0];
    else if (hit(reg_addr, DU_SWAP_OFS))  rd_next = {6'h00, swap_reg};
    else if (hit(reg_addr, DU_OFF_OFS))   rd_next = {4'h0, off_reg};
    else if (hit(reg_addr, DU1_DIVL_OFS)) rd_next = divl_rd[1];
    else if (hit(reg_addr, DU1_CON1_OFS)) rd_next = con1_rd[1];
    else if (hit(reg_addr, DU1_CON2_OFS)) rd_next = con2_rd[1];
    else if (hit(reg_addr, DU1_STAT_OFS)) rd_next = stat_rd[1];
    else if (hit(reg_addr, DU1_DATA_OFS)) rd_next = data_rd[1];
    else                                  rd_next = 8'h00;
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst)         rdata_reg <= 8'h00;
    else if (reg_rd) rdata_reg <= rd_next;
    else             rdata_reg <= 8'h00;
  end

  assign reg_rdata = rdata_reg;

endmodule

//--- du_top_chk.sv
// Concurrent checks for the dual serial block, seen from its ports only.
// Assumes controls change only through the register port it watches.
`timescale 1ns/1ps
module du_top_chk
  import du_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] pad_in,
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe,
  input wire logic [1:0] serial_irq
);
  logic [6:0] c1_reg;
  logic [3:0] c2_reg;
  logic [7:0] dl_reg;
  logic [3:0] off_reg;
  logic       div_one;

  // Shadows of the unit zero controls, so checks need no internal probes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c1_reg  <= 7'h00;
      c2_reg  <= 4'hc;
      dl_reg  <= 8'h00;
      off_reg <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == DU0_CON1_OFS) c1_reg <= reg_wdata[6:0];
      if (reg_addr == DU0_CON2_OFS) c2_reg <= reg_wdata[3:0];
      if (reg_addr == DU0_DIVL_OFS) dl_reg <= reg_wdata;
      if (reg_addr == DU_OFF_OFS) off_reg <= reg_wdata[3:0];
    end
  end

  // The bit length check is armed only at the fastest divisor.
  assign div_one = {c2_reg[1:0], dl_reg} == DIV_ONE;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_clr;
    reg_wr && reg_addr == DU0_STAT_OFS && reg_wdata[2:0] == 3'h0;
  endsequence

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (s_rd(8'hc4) |=> reg_rdata == 8'h00)
    else $error("unmapped address read not zero");
  con1_back_a: assert property (s_rd(DU0_CON1_OFS) |=> reg_rdata == {1'b0, c1_reg})
    else $error("control one readback wrong");
  con2_back_a: assert property (s_rd(DU0_CON2_OFS) |=> reg_rdata == {4'h0, c2_reg})
    else $error("control two readback wrong");
  flag_clear_a: assert property (s_clr ##2 s_rd(DU0_STAT_OFS) |=> reg_rdata[2:0] == 3'h0)
    else $error("error flags not cleared by zero write");
  tx_one_pad_a: assert property (!(pad_oe[0] && pad_oe[1]) && !(pad_oe[2] && pad_oe[3]))
    else $error("both pads of a unit driven");
  // The line idles one cycle after the enable drops and reaches the pad one cycle later.
  idle_high_a: assert property (!c1_reg[C1_EN] && !$past(c1_reg[C1_EN]) && !$past(c1_reg[C1_EN], 2)
    |-> pad_out[1:0] == 2'b11)
    else $error("disabled unit line not idle high");
  bit_len_a: assert property (div_one && $fell(pad_out[0]) |->
    (!pad_out[0]) [*8] ##1 (!pad_out[0]) [*8])
    else $error("low bit shorter than sixteen clocks");
  irq_gate_a: assert property (c2_reg[3:2] == 2'b00 |-> !serial_irq[0])
    else $error("request with both enables off");
  pin_off_a: assert property (off_reg[0] && $past(off_reg[0]) |-> !pad_oe[0])
    else $error("disabled transmit pad driven");
endmodule

bind du_top du_top_chk du_top_chk_i (
  .clk        (clk),
  .rst        (rst),
  .reg_addr   (reg_addr),
  .reg_wdata  (reg_wdata),
  .reg_wr     (reg_wr),
  .reg_rd     (reg_rd),
  .reg_rdata  (reg_rdata),
  .pad_in     (pad_in),
  .pad_out    (pad_out),
  .pad_oe     (pad_oe),
  .serial_irq (serial_irq)
);

//--- du_remote.sv
// Model of the remote serial device on the unit zero lines.
// Assumes a divisor of one, so sixteen clocks make one bit.
`timescale 1ns/1ps
module du_remote (
  input  wire logic       clk,
  input  wire logic       rx_line,
  output logic            tx_line,
  output logic      [8:0] got,
  output int              nframes
);
  localparam int BITC = 16;

  initial begin
    tx_line = 1'b1;
    got     = 9'h000;
    nframes = 0;
  end

  // Receiver keeps nine slots, so an eight bit frame shows its stop in bit eight.
  // It samples on the falling edge, where the registered pad has settled.
  always begin
    @(negedge clk);
    if (rx_line === 1'b0) begin
      repeat (BITC / 2) @(negedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BITC) @(negedge clk);
        got[i] = rx_line;
      end
      nframes = nframes + 1;
      while (rx_line !== 1'b1) @(negedge clk);
    end
  end

  // Sender drives two stop slots so a bad first or second stop can be made.
  task automatic send(input logic [8:0] d, input int nb, input logic [1:0] st);
    @(posedge clk);
    tx_line <= 1'b0;
    repeat (BITC) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      tx_line <= d[i];
      repeat (BITC) @(posedge clk);
    end
    tx_line <= st[0];
    repeat (BITC) @(posedge clk);
    tx_line <= st[1];
    repeat (BITC) @(posedge clk);
    tx_line <= 1'b1;
    repeat (BITC * 2) @(posedge clk);
  endtask
endmodule

//--- du_top_tb.sv
// Self-checking bench for the dual serial block and its remote partner.
// Assumes undriven pads are pulled up, as an idle serial line would be.
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module du_top_tb;
  logic       clk;
  logic       rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [3:0] pad_out;
  logic [3:0] pad_oe;
  logic [1:0] serial_irq;
  logic [3:0] pad_lvl;
  logic       rem_tx;
  logic [8:0] got;
  int         nframes;
  logic [7:0] rv;
  int         err_count = 0;
  int         num_checks = 0;

  // Pad levels: driven pads show the block, pad one carries the remote sender.
  assign pad_lvl = (pad_oe & pad_out) | (~pad_oe & {2'b11, rem_tx, 1'b1});

  du_top du_top_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_lvl),
    .pad_out(pad_out), .pad_oe(pad_oe), .serial_irq(serial_irq));
  du_remote du_remote_i (.clk(clk), .rx_line(pad_lvl[0]), .tx_line(rem_tx), .got(got),
    .nframes(nframes));

  always #5 clk = ~clk;

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
    `CHK($sformatf("reg %h", a), e, rv & m)
  endtask

  // Transmit waits on the partner's frame count, bounded against a hang.
  task automatic xmit(input logic [7:0] d);
    int n0;
    n0 = nframes;
    wr(8'hc1, d);
    for (int i = 0; i < 400 && nframes == n0; i++) @(posedge clk);
    `CHK("frame seen", 1'b1, nframes != n0)
    cyc(40);
  endtask

  task automatic snd(input logic [8:0] d, input int nb, input logic [1:0] st);
    du_remote_i.send(d, nb, st);
    cyc(4);
  endtask

  initial begin
    #400000;
    err_count++;
    close_out;
  end

  initial begin
    int i;
    int n0;
    clk = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc(8'hc1, 8'hff, 8'hff);
    rc(8'hbf, 8'hff, 8'h0c);
    rc(8'hc7, 8'hff, 8'h0c);
    rc(8'hc0, 8'hff, 8'h00);
    rc(8'hc8, 8'hff, 8'h00);
    rc(8'hc4, 8'hff, 8'h00);
    `CHK("irq", 2'b00, serial_irq)
    wr(8'hc2, 8'hff);
    rc(8'hc2, 8'hff, 8'h03);
    wr(8'hc3, 8'hff);
    rc(8'hc3, 8'hff, 8'h0f);
    wr(8'hc2, 8'h00);
    wr(8'hc3, 8'h00);
    wr(8'hbd, 8'h02);
    wr(8'hbe, 8'h40);
    wr(8'hc1, 8'h00);
    for (i = 0; i < 400 && pad_out[0] !== 1'b0; i++) @(posedge clk);
    for (i = 0; i < 999 && pad_out[0] === 1'b0; i++) @(posedge clk);
    `CHK("low run", 288, i)
    cyc(80);
    rc(8'hc0, 8'hff, 8'h10);
    `CHK("irq", 1'b1, serial_irq[0])
    // Writing ones leaves the flags alone but does load the ninth transmit bit.
    wr(8'hc0, 8'hff);
    rc(8'hc0, 8'hff, 8'h30);
    wr(8'hbf, 8'h00);
    cyc(1);
    `CHK("irq", 1'b0, serial_irq[0])
    wr(8'hbf, 8'h0c);
    wr(8'hc0, 8'h00);
    rc(8'hc0, 8'hff, 8'h00);
    wr(8'hbd, 8'h01);
    xmit(8'ha5);
    `CHK("line", 9'h1a5, got)
    wr(8'hbe, 8'h60);
    snd(9'h03c, 8, 2'b11);
    rc(8'hc0, 8'hff, 8'h18);
    rc(8'hc1, 8'hff, 8'h3c);
    snd(9'h05a, 8, 2'b11);
    rc(8'hc0, 8'hff, 8'h1c);
    rc(8'hc1, 8'hff, 8'h3c);
    wr(8'hc0, 8'h00);
    rc(8'hc0, 8'hff, 8'h00);
    snd(9'h0ff, 8, 2'b10);
    rc(8'hc0, 8'h02, 8'h02);
    wr(8'hbe, 8'h62);
    cyc(100);
    wr(8'hc0, 8'h00);
    snd(9'h001, 9, 2'b11);
    rc(8'hc0, 8'h01, 8'h01);
    wr(8'hc0, 8'h00);
    snd(9'h101, 9, 2'b11);
    rc(8'hc0, 8'h01, 8'h00);
    wr(8'hc0, 8'h20);
    rc(8'hc0, 8'h20, 8'h00);
    wr(8'hbe, 8'h63);
    xmit(8'h01);
    `CHK("line", 9'h001, got)
    wr(8'hbe, 8'h64);
    wr(8'hc0, 8'h20);
    rc(8'hc0, 8'h20, 8'h20);
    xmit(8'h80);
    `CHK("line", 9'h180, got)
    snd(9'h155, 9, 2'b11);
    rc(8'hc0, 8'h48, 8'h48);
    rc(8'hc1, 8'hff, 8'h55);
    wr(8'hbe, 8'h74);
    wr(8'hc0, 8'h00);
    snd(9'h033, 9, 2'b11);
    rc(8'hc0, 8'h08, 8'h00);
    snd(9'h144, 9, 2'b11);
    rc(8'hc0, 8'h08, 8'h08);
    rc(8'hc1, 8'hff, 8'h44);
    wr(8'hbe, 8'h68);
    wr(8'hc0, 8'h00);
    snd(9'h0aa, 8, 2'b01);
    rc(8'hc0, 8'h02, 8'h02);
    wr(8'hbe, 8'h40);
    cyc(100);
    wr(8'hc0, 8'h00);
    snd(9'h011, 8, 2'b11);
    rc(8'hc0, 8'h08, 8'h00);
    wr(8'hbe, 8'h60);
    wr(8'hc3, 8'h02);
    snd(9'h011, 8, 2'b11);
    rc(8'hc0, 8'h08, 8'h00);
    wr(8'hc3, 8'h01);
    cyc(2);
    `CHK("oe", 1'b0, pad_oe[0])
    wr(8'hc3, 8'h00);
    wr(8'hc2, 8'h01);
    cyc(2);
    `CHK("oe", 2'b10, pad_oe[1:0])
    wr(8'hc2, 8'h00);
    // The second unit, enabled with a zero divisor, drives pad A and idles high.
    wr(8'hc6, 8'h40);
    cyc(2);
    `CHK("oe1", 2'b01, pad_oe[3:2])
    `CHK("pad1", 2'b11, pad_out[3:2])
    rc(8'hc9, 8'hff, 8'hff);
    wr(8'hbd, 8'h00);
    n0 = nframes;
    wr(8'hc1, 8'h11);
    cyc(300);
    `CHK("frames", n0, nframes)
    wr(8'hbe, 8'h00);
    wr(8'hbd, 8'h01);
    cyc(300);
    `CHK("frames", n0, nframes)
    close_out;
  end
endmodule
